// ===== hdl/sdrrpm_pkg.sv
package sdrrpm_pkg;
	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ      = 100;
	localparam int ROWCYC_SLOW_NS  = 70;
	localparam int ROWCYC_FAST_NS  = 67;
	localparam int ROWCYC_SLOW_CYC = (ROWCYC_SLOW_NS * CLK_MHZ + 999) / 1000;
	localparam int ROWCYC_FAST_CYC = (ROWCYC_FAST_NS * CLK_MHZ + 999) / 1000;
	localparam int SREX_CYC     = 1;
	localparam int DQZ_CYC      = 2;
	localparam int DQW_CYC      = 0;
	localparam int CSL_CYC      = 1;
	localparam int PD_LAT_CYC   = 1;
	localparam int TREF_MS      = 64;
	localparam int TREF_CYC     = TREF_MS * CLK_MHZ * 1000;

	// ---------------------------------------------------------------
	// array geometry
	// ---------------------------------------------------------------
	localparam int ROW_W     = 13;
	localparam int BANK_W    = 2;
	localparam int NUM_BANKS = 4;
	localparam int ADDR_W    = 13;
	localparam int DQM_W     = 2;
	localparam int AP_BIT    = 10;
	localparam int SR_INTERVAL_CYC = TREF_CYC / (2 ** (ROW_W + BANK_W));

	// ---------------------------------------------------------------
	// extended mode register fields
	// ---------------------------------------------------------------
	localparam logic [1:0] EXT_MODE_BA = 2'h2;
	localparam logic [1:0] MODE_BA     = 2'h0;
	localparam int         PASR_LSB    = 0;
	localparam int         PASR_W      = 3;
	localparam int         TCSR_LSB    = 3;
	localparam int         TCSR_W      = 2;
	localparam logic [2:0] PASR_ALL    = 3'h0;
	localparam logic [2:0] PASR_HALF   = 3'h1;
	localparam logic [2:0] PASR_QUART  = 3'h2;
	localparam logic [2:0] PASR_RST    = 3'h0;
	localparam logic [1:0] TCSR_RST    = 2'h0;
	localparam logic [3:0] MASK_ALL    = 4'hF;
	localparam logic [3:0] MASK_HALF   = 4'h3;
	localparam logic [3:0] MASK_QUART  = 4'h1;
	localparam logic [1:0] TCSR_SHIFT0 = 2'h0;
	localparam logic [1:0] TCSR_SHIFT1 = 2'h1;
	localparam logic [1:0] TCSR_SHIFT2 = 2'h2;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_AREF, ST_SREF, ST_PDOWN, ST_SUSPEND, ST_DPD
	} sdrrpm_state_t;

	typedef enum logic [3:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
		CMD_AREF, CMD_SREF, CMD_MODE, CMD_BST, CMD_DPD
	} sdrrpm_cmd_t;
endpackage

// ===== hdl/sdrrpm_refresh_ctr.sv
module sdrrpm_refresh_ctr #(
	parameter int ROW_W  = 13,
	parameter int BANK_W = 2
) (
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	// request
	input  wire logic                  i_req,
	input  wire logic [2**BANK_W-1:0]  i_bank_sel,
	// refresh issued
	output logic                       o_strobe,
	output logic [ROW_W-1:0]           o_row,
	output logic [BANK_W-1:0]          o_bank
);
	logic [ROW_W-1:0]  row_q;
	logic [BANK_W-1:0] bank_q;

	// ---------------------------------------------------------------
	// row and bank counter
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			row_q  <= '0;
			bank_q <= '0;
		end else if (i_req) begin
			// bank advances first, then row
			bank_q <= bank_q + 1'b1;
			if (bank_q == {BANK_W{1'b1}}) begin
				row_q <= row_q + 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// issued refresh, skipped for unselected banks
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_strobe <= 1'b0;
			o_row    <= '0;
			o_bank   <= '0;
		end else begin
			o_strobe <= i_req && i_bank_sel[bank_q];
			if (i_req) begin
				o_row  <= row_q;
				o_bank <= bank_q;
			end
		end
	end
endmodule // sdrrpm_refresh_ctr

// ===== hdl/sdrrpm_top.sv
module sdrrpm_top #(
	parameter bit FAST_GRADE      = 1'b0,
	parameter int TREF_CYC        = sdrrpm_pkg::TREF_CYC,
	parameter int SR_INTERVAL_CYC = sdrrpm_pkg::SR_INTERVAL_CYC
) (
	// clock and reset
	input  wire logic                             i_core_clk,
	input  wire logic                             i_nrst,
	// command pins
	input  wire logic                             i_cs_n,
	input  wire logic                             i_ras_n,
	input  wire logic                             i_cas_n,
	input  wire logic                             i_we_n,
	input  wire logic                             i_cke,
	input  wire logic [sdrrpm_pkg::BANK_W-1:0]    i_ba,
	input  wire logic [sdrrpm_pkg::ADDR_W-1:0]    i_addr,
	input  wire logic [sdrrpm_pkg::DQM_W-1:0]     i_dqm,
	// refresh
	output logic                                  o_refresh_strobe,
	output logic [sdrrpm_pkg::ROW_W-1:0]          o_refresh_row,
	output logic [sdrrpm_pkg::BANK_W-1:0]         o_refresh_bank,
	output logic                                  o_array_busy,
	// power modes
	output logic                                  o_self_refresh,
	output logic                                  o_power_down,
	output logic                                  o_clock_suspend,
	output logic                                  o_deep_power_down,
	output logic                                  o_int_clk_en,
	output logic                                  o_rx_enable,
	output logic                                  o_vgen_enable,
	output logic                                  o_need_init,
	// data masking
	output logic [sdrrpm_pkg::DQM_W-1:0]          o_dq_out_disable,
	output logic [sdrrpm_pkg::DQM_W-1:0]          o_write_mask,
	// bank status
	output logic [sdrrpm_pkg::NUM_BANKS-1:0]      o_bank_open,
	output logic [sdrrpm_pkg::NUM_BANKS-1:0]      o_bank_valid,
	output logic                                  o_cmd_error
);
	localparam int ROWCYC_CYC = FAST_GRADE ? sdrrpm_pkg::ROWCYC_FAST_CYC
	                                       : sdrrpm_pkg::ROWCYC_SLOW_CYC;
	localparam int NB = sdrrpm_pkg::NUM_BANKS;

	logic                               rst_meta_q;
	logic                               rst_n;
	logic                               p_cs_n;
	logic                               p_ras_n;
	logic                               p_cas_n;
	logic                               p_we_n;
	logic                               p_cke;
	logic                               cke_prev_q;
	logic [sdrrpm_pkg::BANK_W-1:0]      p_ba;
	logic [sdrrpm_pkg::ADDR_W-1:0]      p_addr;
	logic [sdrrpm_pkg::DQM_W-1:0]       p_dqm;
	sdrrpm_pkg::sdrrpm_cmd_t            cmd;
	sdrrpm_pkg::sdrrpm_state_t          state_q;
	logic                               all_idle;
	logic                               take_cmd;
	logic [3:0]                         rowcyc_cnt_q;
	logic [2:0]                         pasr_q;
	logic [1:0]                         tcsr_q;
	logic [NB-1:0]                      pasr_mask;
	logic [11:0]                        sr_tick_q;
	logic [11:0]                        sr_period;
	logic [22:0]                        tref_cnt_q;
	logic                               sr_req;
	logic                               ref_req;
	logic [sdrrpm_pkg::DQM_W-1:0]       dqz_s1_q;

	// ---------------------------------------------------------------
	// reset release and pin registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			p_cs_n     <= 1'b1;
			p_ras_n    <= 1'b1;
			p_cas_n    <= 1'b1;
			p_we_n     <= 1'b1;
			p_cke      <= 1'b1;
			cke_prev_q <= 1'b1;
			p_ba       <= '0;
			p_addr     <= '0;
			p_dqm      <= '0;
		end else begin
			p_cs_n     <= i_cs_n;
			p_ras_n    <= i_ras_n;
			p_cas_n    <= i_cas_n;
			p_we_n     <= i_we_n;
			p_cke      <= i_cke;
			cke_prev_q <= p_cke;
			p_ba       <= i_ba;
			p_addr     <= i_addr;
			p_dqm      <= i_dqm;
		end
	end

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	always_comb begin
		cmd = sdrrpm_pkg::CMD_NOP;
		if (!p_cs_n) begin
			case ({p_ras_n, p_cas_n, p_we_n})
				3'h3: cmd = sdrrpm_pkg::CMD_ACT;
				3'h5: cmd = sdrrpm_pkg::CMD_RD;
				3'h4: cmd = sdrrpm_pkg::CMD_WR;
				3'h2: cmd = sdrrpm_pkg::CMD_PRE;
				3'h1: cmd = p_cke ? sdrrpm_pkg::CMD_AREF
				                  : sdrrpm_pkg::CMD_SREF;
				3'h0: cmd = sdrrpm_pkg::CMD_MODE;
				3'h6: cmd = p_cke ? sdrrpm_pkg::CMD_BST
				                  : sdrrpm_pkg::CMD_DPD;
				default: cmd = sdrrpm_pkg::CMD_NOP;
			endcase
		end
	end

	assign all_idle = (o_bank_open == '0);
	assign take_cmd = (state_q == sdrrpm_pkg::ST_IDLE) && cke_prev_q;

	// ---------------------------------------------------------------
	// mode state machine
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q      <= sdrrpm_pkg::ST_IDLE;
			rowcyc_cnt_q <= '0;
		end else begin
			case (state_q)
				sdrrpm_pkg::ST_IDLE: begin
					if (take_cmd && all_idle
					    && cmd == sdrrpm_pkg::CMD_AREF) begin
						state_q      <= sdrrpm_pkg::ST_AREF;
						rowcyc_cnt_q <= 4'(ROWCYC_CYC - 1);
					end else if (take_cmd && all_idle
					    && cmd == sdrrpm_pkg::CMD_SREF) begin
						state_q <= sdrrpm_pkg::ST_SREF;
					end else if (take_cmd && all_idle
					    && cmd == sdrrpm_pkg::CMD_DPD) begin
						state_q <= sdrrpm_pkg::ST_DPD;
					end else if (take_cmd && !p_cke
					    && cmd == sdrrpm_pkg::CMD_NOP) begin
						state_q <= all_idle ? sdrrpm_pkg::ST_PDOWN
						                    : sdrrpm_pkg::ST_SUSPEND;
					end
				end
				sdrrpm_pkg::ST_AREF: begin
					rowcyc_cnt_q <= rowcyc_cnt_q - 1'b1;
					// busy stands for a full row cycle of samples
					if (rowcyc_cnt_q == 4'h0) begin
						state_q <= sdrrpm_pkg::ST_IDLE;
					end
				end
				sdrrpm_pkg::ST_SREF: begin
					if (p_cke) begin
						state_q <= sdrrpm_pkg::ST_IDLE;
					end
				end
				sdrrpm_pkg::ST_PDOWN, sdrrpm_pkg::ST_SUSPEND,
				sdrrpm_pkg::ST_DPD: begin
					if (p_cke) begin
						state_q <= sdrrpm_pkg::ST_IDLE;
					end
				end
				default: state_q <= sdrrpm_pkg::ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// bank open tracking and command errors
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_bank_open <= '0;
			o_cmd_error <= 1'b0;
		end else begin
			o_cmd_error <= 1'b0;
			if (take_cmd) begin
				case (cmd)
					sdrrpm_pkg::CMD_ACT: o_bank_open[p_ba] <= 1'b1;
					sdrrpm_pkg::CMD_PRE: begin
						if (p_addr[sdrrpm_pkg::AP_BIT]) begin
							o_bank_open <= '0;
						end else begin
							o_bank_open[p_ba] <= 1'b0;
						end
					end
					sdrrpm_pkg::CMD_AREF, sdrrpm_pkg::CMD_SREF,
					sdrrpm_pkg::CMD_DPD, sdrrpm_pkg::CMD_MODE:
						o_cmd_error <= !all_idle;
					default: o_cmd_error <= 1'b0;
				endcase
			end else if (state_q == sdrrpm_pkg::ST_AREF
			             && cmd != sdrrpm_pkg::CMD_NOP) begin
				o_cmd_error <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// mode register and extended mode register
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pasr_q      <= sdrrpm_pkg::PASR_RST;
			tcsr_q      <= sdrrpm_pkg::TCSR_RST;
			o_need_init <= 1'b1;
		end else if (take_cmd && all_idle && cmd == sdrrpm_pkg::CMD_MODE) begin
			if (p_ba == sdrrpm_pkg::EXT_MODE_BA) begin
				pasr_q <= p_addr[sdrrpm_pkg::PASR_LSB +: sdrrpm_pkg::PASR_W];
				tcsr_q <= p_addr[sdrrpm_pkg::TCSR_LSB +: sdrrpm_pkg::TCSR_W];
			end else if (p_ba == sdrrpm_pkg::MODE_BA) begin
				o_need_init <= 1'b0;
			end
		end else if (state_q == sdrrpm_pkg::ST_DPD) begin
			o_need_init <= 1'b1;
		end
	end

	always_comb begin
		case (pasr_q)
			sdrrpm_pkg::PASR_HALF:  pasr_mask = sdrrpm_pkg::MASK_HALF;
			sdrrpm_pkg::PASR_QUART: pasr_mask = sdrrpm_pkg::MASK_QUART;
			default:                pasr_mask = sdrrpm_pkg::MASK_ALL;
		endcase
		case (tcsr_q)
			2'h1:    sr_period = 12'(SR_INTERVAL_CYC) << sdrrpm_pkg::TCSR_SHIFT1;
			2'h2:    sr_period = 12'(SR_INTERVAL_CYC) << sdrrpm_pkg::TCSR_SHIFT2;
			default: sr_period = 12'(SR_INTERVAL_CYC) << sdrrpm_pkg::TCSR_SHIFT0;
		endcase
	end

	// ---------------------------------------------------------------
	// self refresh timer and data retention
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_tick_q <= '0;
		end else if (state_q != sdrrpm_pkg::ST_SREF || sr_req) begin
			sr_tick_q <= '0;
		end else begin
			sr_tick_q <= sr_tick_q + 1'b1;
		end
	end
	assign sr_req = (state_q == sdrrpm_pkg::ST_SREF)
	                && (sr_tick_q == sr_period - 1'b1);

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tref_cnt_q   <= '0;
			o_bank_valid <= sdrrpm_pkg::MASK_ALL;
		end else begin
			if (state_q != sdrrpm_pkg::ST_SREF) begin
				tref_cnt_q <= '0;
			end else if (tref_cnt_q != 23'(TREF_CYC)) begin
				tref_cnt_q <= tref_cnt_q + 1'b1;
			end
			if (state_q == sdrrpm_pkg::ST_DPD) begin
				o_bank_valid <= '0;
			end else if (tref_cnt_q == 23'(TREF_CYC)) begin
				o_bank_valid <= o_bank_valid & pasr_mask;
			end else if (take_cmd && cmd == sdrrpm_pkg::CMD_WR) begin
				o_bank_valid[p_ba] <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// refresh counter
	// ---------------------------------------------------------------
	assign ref_req = (take_cmd && all_idle && cmd == sdrrpm_pkg::CMD_AREF)
	                 || sr_req;

	sdrrpm_refresh_ctr #(
		.ROW_W  (sdrrpm_pkg::ROW_W),
		.BANK_W (sdrrpm_pkg::BANK_W)
	) u_ctr (
		.i_clk      (i_core_clk),
		.i_rst_n    (rst_n),
		.i_req      (ref_req),
		.i_bank_sel (sr_req ? pasr_mask : sdrrpm_pkg::MASK_ALL),
		.o_strobe   (o_refresh_strobe),
		.o_row      (o_refresh_row),
		.o_bank     (o_refresh_bank)
	);

	// ---------------------------------------------------------------
	// mode outputs and data masks
	// ---------------------------------------------------------------
	assign o_array_busy      = (state_q == sdrrpm_pkg::ST_AREF);
	assign o_self_refresh    = (state_q == sdrrpm_pkg::ST_SREF);
	assign o_power_down      = (state_q == sdrrpm_pkg::ST_PDOWN);
	assign o_clock_suspend   = (state_q == sdrrpm_pkg::ST_SUSPEND);
	assign o_deep_power_down = (state_q == sdrrpm_pkg::ST_DPD);
	assign o_int_clk_en      = !(o_self_refresh || o_power_down
	                             || o_clock_suspend || o_deep_power_down);
	assign o_rx_enable       = !(o_self_refresh || o_power_down
	                             || o_deep_power_down);
	assign o_vgen_enable     = !o_deep_power_down;
	assign o_write_mask      = p_dqm;

	// read disable pipeline freezes with the internal clock
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dqz_s1_q         <= '0;
			o_dq_out_disable <= '0;
		end else if (o_int_clk_en) begin
			dqz_s1_q         <= p_dqm;
			o_dq_out_disable <= dqz_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_aref_taken;
		take_cmd && all_idle && cmd == sdrrpm_pkg::CMD_AREF;
	endsequence
	sequence s_sref_taken;
		take_cmd && all_idle && cmd == sdrrpm_pkg::CMD_SREF;
	endsequence

	chk_aref_decode: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) s_aref_taken |=> o_array_busy && o_refresh_strobe)
		else $error("auto refresh not started");
	chk_aref_hold: assert property (@(posedge i_core_clk)
		disable iff (!rst_n)
		s_aref_taken |=> o_array_busy [*7] ##1 !o_array_busy && all_idle)
		else $error("auto refresh span wrong");
	chk_sref_entry: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) s_sref_taken |=> o_self_refresh && !o_rx_enable)
		else $error("self refresh not entered");
	chk_sref_exit: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) o_self_refresh && p_cke |=> !o_self_refresh)
		else $error("self refresh exit late");
	chk_sref_ignore: assert property (@(posedge i_core_clk)
		disable iff (!rst_n)
		o_self_refresh && !p_cke |=> o_self_refresh && $stable(o_bank_open))
		else $error("input heeded in self refresh");
	chk_pasr_skip: assert property (@(posedge i_core_clk)
		disable iff (!rst_n)
		o_refresh_strobe && $past(o_self_refresh) |-> pasr_mask[o_refresh_bank])
		else $error("unselected bank refreshed");
	chk_dqz_latency: assert property (@(posedge i_core_clk)
		disable iff (!rst_n)
		$past(o_int_clk_en) && $past(o_int_clk_en, 2)
		|-> o_dq_out_disable == $past(p_dqm, 2))
		else $error("read disable latency wrong");
	chk_pd_entry: assert property (@(posedge i_core_clk)
		disable iff (!rst_n)
		take_cmd && all_idle && !p_cke && cmd == sdrrpm_pkg::CMD_NOP
		|=> o_power_down ##0 !o_rx_enable)
		else $error("power down entry wrong");
	chk_suspend_freeze: assert property (@(posedge i_core_clk)
		disable iff (!rst_n)
		o_clock_suspend |=> $stable(o_dq_out_disable))
		else $error("pipeline moved in suspend");
	chk_dpd_loss: assert property (@(posedge i_core_clk)
		disable iff (!rst_n)
		o_deep_power_down |=> o_bank_valid == '0 && o_need_init)
		else $error("deep power down kept data");
endmodule // sdrrpm_top

// ===== bench/sdrrpm_ctl_model.sv
module sdrrpm_ctl_model #(
	parameter int GAP_CYC = 10
) (
	// clock
	input  wire logic                          i_clk,
	// command pins
	output logic                               o_cs_n,
	output logic                               o_ras_n,
	output logic                               o_cas_n,
	output logic                               o_we_n,
	output logic                               o_cke,
	output logic [sdrrpm_pkg::BANK_W-1:0]      o_ba,
	output logic [sdrrpm_pkg::ADDR_W-1:0]      o_addr,
	output logic [sdrrpm_pkg::DQM_W-1:0]       o_dqm
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_cs_n = 1'b0;
		{o_ras_n, o_cas_n, o_we_n} = 3'h7;
		o_cke = 1'b1;
		o_ba = '0;
		o_addr = '0;
		o_dqm = '0;
	end

	// one command for one cycle, then nop with cke held
	task automatic send(input logic [2:0] rcw, input logic cke,
		input logic [1:0] ba, input logic [12:0] a);
		repeat (GAP_CYC) @(posedge i_clk);
		@(posedge i_clk);
		{o_ras_n, o_cas_n, o_we_n} <= rcw;
		o_cke <= cke;
		o_ba <= ba;
		o_addr <= a;
		@(posedge i_clk);
		{o_ras_n, o_cas_n, o_we_n} <= 3'h7;
		#1;
	endtask

	task automatic mask(input logic [1:0] m);
		@(posedge i_clk);
		o_dqm <= m;
	endtask
endmodule // sdrrpm_ctl_model

// ===== bench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] C_NOP = 3'h7;
	localparam logic [2:0] C_ACT = 3'h3;
	localparam logic [2:0] C_PRE = 3'h2;
	localparam logic [2:0] C_REF = 3'h1;
	localparam logic [2:0] C_MODE = 3'h0;
	localparam logic [2:0] C_WR  = 3'h4;
	localparam logic [2:0] C_DPD = 3'h6;
	typedef struct {logic [12:0] a; logic [12:0] row; logic [1:0] bank;}
		sdrrpm_tb_row_t;
	sdrrpm_tb_row_t rows [5] = '{'{13'h1FFF, 13'h0, 2'h0},
		'{13'h0000, 13'h0, 2'h1}, '{13'h0400, 13'h0, 2'h2},
		'{13'h1555, 13'h0, 2'h3}, '{13'h0ABC, 13'h1, 2'h0}};
	logic        i_core_clk = 1'b0;
	logic        i_nrst = 1'b0;
	logic        cs_n, ras_n, cas_n, we_n, cke;
	logic [1:0]  ba, dqm, o_dq_out_disable, o_write_mask, o_refresh_bank;
	logic [12:0] addr, o_refresh_row;
	logic [3:0]  o_bank_open, o_bank_valid;
	logic        o_refresh_strobe, o_array_busy, o_self_refresh, o_power_down;
	logic        o_clock_suspend, o_deep_power_down, o_int_clk_en;
	logic        o_rx_enable, o_vgen_enable, o_need_init, o_cmd_error;
	int          n_fail = 0;
	int          n_checks = 0;
	int          n_strobe = 0;
	int          n_bad = 0;
	int          n, mw, mz;

	always #5 i_core_clk = ~i_core_clk;

	sdrrpm_ctl_model u_ctl (.i_clk(i_core_clk), .o_cs_n(cs_n),
		.o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_cke(cke),
		.o_ba(ba), .o_addr(addr), .o_dqm(dqm));

	sdrrpm_top #(.TREF_CYC(2000), .SR_INTERVAL_CYC(10)) u_dut (
		.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_cs_n(cs_n),
		.i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_cke(cke),
		.i_ba(ba), .i_addr(addr), .i_dqm(dqm),
		.o_refresh_strobe(o_refresh_strobe), .o_refresh_row(o_refresh_row),
		.o_refresh_bank(o_refresh_bank), .o_array_busy(o_array_busy),
		.o_self_refresh(o_self_refresh), .o_power_down(o_power_down),
		.o_clock_suspend(o_clock_suspend),
		.o_deep_power_down(o_deep_power_down), .o_int_clk_en(o_int_clk_en),
		.o_rx_enable(o_rx_enable), .o_vgen_enable(o_vgen_enable),
		.o_need_init(o_need_init), .o_dq_out_disable(o_dq_out_disable),
		.o_write_mask(o_write_mask), .o_bank_open(o_bank_open),
		.o_bank_valid(o_bank_valid), .o_cmd_error(o_cmd_error));

	// strobes in self refresh must stay in the selected bank
	always @(posedge i_core_clk) begin
		if (o_refresh_strobe === 1'b1) begin
			n_strobe++;
			if (o_self_refresh === 1'b1 && o_refresh_bank !== 2'h0)
				n_bad++;
		end
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic edges(input int k);
		repeat (k) @(posedge i_core_clk);
		#1;
	endtask

	task automatic do_reset;
		@(posedge i_core_clk);
		i_nrst <= 1'b0;
		edges(4);
		compare({o_need_init, o_bank_valid, o_int_clk_en, o_rx_enable,
			o_vgen_enable, o_self_refresh, o_power_down, o_array_busy},
			16'h07F8);
		@(posedge i_core_clk);
		i_nrst <= 1'b1;
		edges(3);
		u_ctl.send(C_MODE, 1'b1, 2'h0, 13'h0000);
	endtask

	task automatic aref(input sdrrpm_tb_row_t r);
		u_ctl.send(C_REF, 1'b1, 2'h3, r.a);
		compare(o_refresh_strobe, 1'b0);
		edges(1);
		compare({o_refresh_strobe, o_refresh_bank, o_refresh_row},
			{1'b1, r.bank, r.row});
		n = 0;
		while (o_array_busy === 1'b1 && n < 20) begin
			n++;
			edges(1);
		end
		compare(n, sdrrpm_pkg::ROWCYC_SLOW_CYC);
		compare(o_bank_open, 4'h0);
	endtask

	task automatic results;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (10000) @(posedge i_core_clk);
		n_fail++;
		results();
	end

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		do_reset();
		foreach (rows[i])
			aref(rows[i]);
		do_reset();
		u_ctl.send(C_MODE, 1'b1, sdrrpm_pkg::EXT_MODE_BA,
			{8'h00, sdrrpm_pkg::TCSR_SHIFT1, sdrrpm_pkg::PASR_QUART});
		aref(rows[0]);
		aref(rows[1]);
		u_ctl.send(C_REF, 1'b0, 2'h0, 13'h0000);
		n_strobe = 0;
		edges(1);
		compare({o_self_refresh, o_rx_enable, o_int_clk_en}, 3'h4);
		u_ctl.send(C_ACT, 1'b0, 2'h2, 13'h0000);
		edges(2100);
		compare(o_bank_open, 4'h0);
		compare(o_bank_valid, sdrrpm_pkg::MASK_QUART);
		compare(n_bad, 0);
		// a request every doubled interval, one in four lands in bank 0
		compare(n_strobe >= 25 && n_strobe <= 27, 1'b1);
		u_ctl.send(C_NOP, 1'b1, 2'h0, 13'h0000);
		edges(1);
		compare(o_self_refresh, 1'b0);
		u_ctl.send(C_REF, 1'b1, 2'h0, 13'h0000);
		edges(1);
		compare(o_refresh_strobe, 1'b1);
		u_ctl.send(C_NOP, 1'b0, 2'h0, 13'h0000);
		compare(o_power_down, 1'b0);
		edges(1);
		compare({o_power_down, o_rx_enable, o_int_clk_en}, 3'h4);
		u_ctl.send(C_NOP, 1'b1, 2'h0, 13'h0000);
		compare(o_power_down, 1'b1);
		edges(1);
		compare(o_power_down, 1'b0);
		u_ctl.send(C_ACT, 1'b1, 2'h1, 13'h0000);
		edges(1);
		compare(o_bank_open, 4'h2);
		u_ctl.send(C_NOP, 1'b0, 2'h0, 13'h0000);
		edges(1);
		compare({o_clock_suspend, o_power_down, o_int_clk_en}, 3'h4);
		u_ctl.send(C_NOP, 1'b1, 2'h0, 13'h0000);
		edges(1);
		compare(o_clock_suspend, 1'b0);
		// a write makes a bank lost in partial array refresh valid again
		u_ctl.send(C_WR, 1'b1, 2'h1, 13'h0000);
		edges(1);
		compare(o_bank_valid, 4'h3);
		u_ctl.mask(2'h3);
		mw = 0;
		mz = 0;
		for (int k = 1; k < 7; k++) begin
			edges(1);
			if (mw == 0 && o_write_mask === 2'h3)
				mw = k;
			if (mz == 0 && o_dq_out_disable === 2'h3)
				mz = k;
		end
		compare(mw, 1);
		compare(mz - mw, sdrrpm_pkg::DQZ_CYC);
		u_ctl.mask(2'h0);
		u_ctl.send(C_REF, 1'b1, 2'h0, 13'h0000);
		edges(1);
		compare({o_cmd_error, o_refresh_strobe}, 2'h2);
		u_ctl.send(C_PRE, 1'b1, 2'h0, 13'h0400);
		edges(1);
		compare(o_bank_open, 4'h0);
		u_ctl.send(C_DPD, 1'b0, 2'h0, 13'h0000);
		// bank data is dropped one edge after the mode is entered
		edges(2);
		compare({o_deep_power_down, o_vgen_enable, o_bank_valid}, 6'h20);
		u_ctl.send(C_NOP, 1'b1, 2'h0, 13'h0000);
		edges(1);
		compare({o_deep_power_down, o_need_init}, 2'h1);
		u_ctl.send(C_MODE, 1'b1, 2'h0, 13'h0000);
		edges(1);
		compare(o_need_init, 1'b0);
		results();
	end
endmodule // tb_top
